// *** src/dial_seq_pkg.sv ***
// Functional notes
// - standard code 30 selects v22bis for the 2400 group, sole option.
// - 4800 group: code 41 v32 full duplex, code 42 ping-pong.
// - 9600 group: code 60 v32, 61 ping-pong, 63 v29 half duplex.
// - each speed group keeps its own latest selection independently.
// - carrier normal always accepted; forced off only on low-speed devices.
// - already off hook at dial start skips initial wait and dial tone check.
// - dial refused while on-line or sync mode two or three active.
// - parentheses and hyphens skipped but counted; buffer 40 or 255 chars.
// - busy result if result set three/four or wait modifier used.
// - no dialtone if set two/four lacks 1 s tone, or wait times out.
// - error on bad stored index or line plus stored string overflow.
// - no answer when quiet-answer silence not found before wait limit.
// - ok on terminal-ready abort, trailing semicolon, or terminal character.
// - digits dial either method; a-d, #, * tone only, skipped in pulse.
// - pulse modifier sets pulse for later calls; pulse at power-up.
// - tone modifier sets tone until pulse modifier, a pulse method select in idle, or reset.
// - wait modifier holds until dial tone; timeout hangs up, no dialtone.
// - comma pauses for pause_time seconds before next character.
// - quiet answer waits five seconds silence within limit, else no answer.
// - silence timing starts only after dial tone then signal over 210 ms.
// - hookflash goes on hook briefly then reconnects.
package dial_seq_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SEC_CYCLES = CLK_HZ;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned SIGNAL_MS = 210;
	localparam int unsigned SIGNAL_TICKS = SIGNAL_MS / TICK_MS + 1;
	localparam int unsigned DIALTONE_S = 1;
	localparam int unsigned SILENCE_S = 5;
	localparam int unsigned INIT_WAIT_S = 2;
	localparam int unsigned FLASH_MS = 500;
	localparam int unsigned FLASH_TICKS = FLASH_MS / TICK_MS;
	localparam int unsigned BUF_BASIC = 40;
	localparam int unsigned BUF_EXTENDED = 255;
	localparam int unsigned STORED_SLOTS = 4;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_WAIT = 8'h57;
	localparam logic [7:0] CH_QUIET = 8'h40;
	localparam logic [7:0] CH_FLASH = 8'h21;
	localparam logic [7:0] CH_PULSE = 8'h50;
	localparam logic [7:0] CH_TONE = 8'h54;
	localparam logic [7:0] CH_LPAR = 8'h28;
	localparam logic [7:0] CH_RPAR = 8'h29;
	localparam logic [7:0] CH_HYPH = 8'h2d;
	localparam logic [7:0] CH_SPACE = 8'h20;
	// speed group selection codes
	localparam logic [6:0] STD_2400 = 7'd30;
	localparam logic [6:0] STD_4800_FD = 7'd41;
	localparam logic [6:0] STD_4800_PP = 7'd42;
	localparam logic [6:0] STD_9600_FD = 7'd60;
	localparam logic [6:0] STD_9600_PP = 7'd61;
	localparam logic [6:0] STD_9600_HD = 7'd63;
	typedef enum logic [1:0] {
		MOD_V32 = 2'h0,
		MOD_PINGPONG = 2'h1,
		MOD_V29_HDX = 2'h2,
		MOD_V22BIS = 2'h3
	} mod_std_e;
	typedef enum logic [2:0] {
		RES_NONE = 3'h0,
		RES_OK = 3'h1,
		RES_ERROR = 3'h2,
		RES_BUSY = 3'h3,
		RES_NO_DIALTONE = 3'h4,
		RES_NO_ANSWER = 3'h5,
		RES_DIALED = 3'h6
	} result_e;
	typedef struct packed {
		logic on_line;
		logic sync_mode_two;
		logic sync_mode_three;
		logic result_set_two;
		logic result_set_three;
		logic result_set_four;
		logic [7:0] carrier_wait_time;
		logic [7:0] pause_time;
	} cfg_s;
	typedef struct packed {
		logic dial_tone;
		logic busy_tone;
		logic other_signal;
	} line_s;
	typedef struct packed {
		logic valid;
		logic tone;
		logic [7:0] symbol;
	} digit_s;
endpackage

// *** src/modem_dial_command_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module modem_dial_command_sequencer
	import dial_seq_pkg::*;
#(
	parameter int unsigned BUF_CHARS = BUF_BASIC,
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_char_valid,
	input wire logic [7:0] i_char,
	input wire logic i_dial_start,
	input wire logic i_std_valid,
	input wire logic [6:0] i_std_code,
	input wire logic i_carrier_valid,
	input wire logic i_carrier_off_req,
	input wire logic i_low_speed,
	input wire logic i_method_valid,
	input wire logic i_method_tone,
	input wire logic i_stored_valid,
	input wire logic [2:0] i_stored_index,
	input wire logic [8:0] i_stored_len,
	input wire cfg_s i_cfg,
	input wire line_s i_line_async,
	input wire logic i_term_ready_abort,
	output logic o_cmd_reject,
	output mod_std_e o_std_4800,
	output mod_std_e o_std_9600,
	output mod_std_e o_std_2400,
	output logic o_tx_carrier_forced_off,
	output logic o_tone_mode,
	output logic o_off_hook,
	output logic o_originate,
	output digit_s o_digit,
	output logic o_busy,
	output logic o_result_valid,
	output result_e o_result
);
	initial begin
		if (BUF_CHARS != BUF_BASIC && BUF_CHARS != BUF_EXTENDED)
			$error("buffer size must be basic or extended");
		if (TICK_LEN < 1 || TICK_LEN > 1048576)
			$error("tick length must fit the 20-bit tick counter");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_INIT = 3'h1,
		ST_RUN = 3'h3,
		ST_WAIT = 3'h2,
		ST_PAUSE = 3'h6,
		ST_QUIET = 3'h7,
		ST_FLASH = 3'h5,
		ST_DONE = 3'h4
	} state_e;

	function automatic logic is_digit(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h39;
	endfunction
	function automatic logic is_tone_sym(input logic [7:0] c);
		return (c >= 8'h41 && c <= 8'h44) || c == 8'h23 || c == 8'h2a;
	endfunction

	state_e state_q;
	line_s line_m_q, line_q;
	logic [19:0] tick_cnt_q;
	logic tick;
	logic [15:0] timer_q;
	logic [15:0] limit_q;
	logic [15:0] sub_q;
	logic [8:0] count_q;
	logic used_wait_q, heard_tone_q, armed_q, saw_tone_q;
	logic [15:0] wait_ticks, pause_ticks;

	assign wait_ticks = 16'(i_cfg.carrier_wait_time) * 16'd100;
	assign pause_ticks = 16'(i_cfg.pause_time) * 16'd100;

	// two-stage sync of line detectors, they come from the analog front end
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			line_m_q <= '0;
			line_q <= '0;
		end else begin
			line_m_q <= i_line_async;
			line_q <= line_m_q;
		end
	end

	// 10 ms tick keeps the second-scale timers narrow
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || tick_cnt_q == 20'(TICK_LEN - 1)) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 20'd1;
		end
	end
	assign tick = tick_cnt_q == 20'(TICK_LEN - 1);

	// per-group standard selection, newest in a group wins
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_std_2400 <= MOD_V22BIS;
			o_std_4800 <= MOD_V32;
			o_std_9600 <= MOD_V32;
		end else if (i_std_valid) begin
			unique case (i_std_code)
				STD_2400: o_std_2400 <= MOD_V22BIS;
				STD_4800_FD: o_std_4800 <= MOD_V32;
				STD_4800_PP: o_std_4800 <= MOD_PINGPONG;
				STD_9600_FD: o_std_9600 <= MOD_V32;
				STD_9600_PP: o_std_9600 <= MOD_PINGPONG;
				STD_9600_HD: o_std_9600 <= MOD_V29_HDX;
				default: ;
			endcase
		end
	end

	// carrier control; forced off refused on high-speed devices
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_tx_carrier_forced_off <= 1'b0;
		end else if (i_carrier_valid) begin
			if (!i_carrier_off_req) begin
				o_tx_carrier_forced_off <= 1'b0;
			end else if (i_low_speed) begin
				o_tx_carrier_forced_off <= 1'b1;
			end
		end
	end

	// command-level rejects, one-cycle pulse
	always_comb begin
		o_cmd_reject = 1'b0;
		if (i_std_valid && !(i_std_code inside {STD_2400, STD_4800_FD, STD_4800_PP,
				STD_9600_FD, STD_9600_PP, STD_9600_HD}))
			o_cmd_reject = 1'b1;
		if (i_carrier_valid && i_carrier_off_req && !i_low_speed)
			o_cmd_reject = 1'b1;
	end

	// dialing method persists across calls, pulse at reset
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_tone_mode <= 1'b0;
		end else if (i_method_valid && state_q == ST_IDLE) begin
			o_tone_mode <= i_method_tone;
		end else if (state_q == ST_RUN && i_char_valid) begin
			if (i_char == CH_PULSE)
				o_tone_mode <= 1'b0;
			else if (i_char == CH_TONE)
				o_tone_mode <= 1'b1;
		end
	end

	// dial sequencer; one character consumed at a time, left to right
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			o_off_hook <= 1'b0;
			o_originate <= 1'b0;
			o_digit <= '0;
			o_busy <= 1'b0;
			o_result_valid <= 1'b0;
			o_result <= RES_NONE;
			timer_q <= '0;
			limit_q <= '0;
			sub_q <= '0;
			count_q <= '0;
			used_wait_q <= 1'b0;
			heard_tone_q <= 1'b0;
			armed_q <= 1'b0;
			saw_tone_q <= 1'b0;
		end else begin
			o_digit.valid <= 1'b0;
			o_result_valid <= 1'b0;
			if (tick)
				timer_q <= timer_q + 16'd1;
			unique case (state_q)
				ST_IDLE: begin
					if (i_dial_start) begin
						if (i_cfg.on_line || i_cfg.sync_mode_two || i_cfg.sync_mode_three) begin
							o_result <= RES_ERROR;
							o_result_valid <= 1'b1;
						end else if (i_stored_valid && (32'(i_stored_index) >= STORED_SLOTS
								|| 32'(i_stored_len) > BUF_CHARS)) begin
							o_result <= RES_ERROR;
							o_result_valid <= 1'b1;
						end else begin
							o_busy <= 1'b1;
							o_originate <= 1'b1;
							count_q <= i_stored_valid ? i_stored_len : 9'd0;
							used_wait_q <= 1'b0;
							heard_tone_q <= 1'b0;
							timer_q <= '0;
							// already off hook: straight to the dial string
							state_q <= o_off_hook ? ST_RUN : ST_INIT;
							o_off_hook <= 1'b1;
						end
					end
				end
				ST_INIT: begin
					if (line_q.dial_tone && tick)
						sub_q <= sub_q + 16'd1;
					if (32'(sub_q) >= DIALTONE_S * 100)
						heard_tone_q <= 1'b1;
					if (32'(timer_q) >= INIT_WAIT_S * 100) begin
						sub_q <= '0;
						if ((i_cfg.result_set_two || i_cfg.result_set_four) && !heard_tone_q) begin
							o_result <= RES_NO_DIALTONE;
							o_result_valid <= 1'b1;
							o_off_hook <= 1'b0;
							o_busy <= 1'b0;
							state_q <= ST_IDLE;
						end else begin
							state_q <= ST_RUN;
						end
					end
				end
				ST_RUN: begin
					if (i_term_ready_abort) begin
						o_result <= RES_OK;
						o_result_valid <= 1'b1;
						o_off_hook <= 1'b0;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end else if (line_q.busy_tone && (i_cfg.result_set_three
							|| i_cfg.result_set_four || used_wait_q)) begin
						o_result <= RES_BUSY;
						o_result_valid <= 1'b1;
						o_off_hook <= 1'b0;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end else if (i_char_valid) begin
						count_q <= count_q + 9'd1;
						timer_q <= '0;
						sub_q <= '0;
						if (32'(count_q) >= BUF_CHARS) begin
							o_result <= RES_ERROR;
							o_result_valid <= 1'b1;
							o_off_hook <= 1'b0;
							o_busy <= 1'b0;
							state_q <= ST_IDLE;
						end else if (is_digit(i_char) || (is_tone_sym(i_char) && o_tone_mode)) begin
							o_digit <= '{valid: 1'b1, tone: o_tone_mode, symbol: i_char};
						end else if (i_char == CH_WAIT) begin
							used_wait_q <= 1'b1;
							state_q <= ST_WAIT;
						end else if (i_char == CH_COMMA) begin
							state_q <= ST_PAUSE;
						end else if (i_char == CH_QUIET) begin
							armed_q <= 1'b0;
							saw_tone_q <= 1'b0;
							state_q <= ST_QUIET;
						end else if (i_char == CH_FLASH) begin
							o_off_hook <= 1'b0;
							state_q <= ST_FLASH;
						end else if (i_char == CH_SEMI) begin
							o_result <= RES_OK;
							state_q <= ST_DONE;
						end else if (i_char == CH_CR) begin
							o_result <= RES_DIALED;
							state_q <= ST_DONE;
						end
						// parentheses, hyphens, pulse-mode tone symbols: counted only
					end
				end
				ST_WAIT: begin
					if (line_q.dial_tone) begin
						state_q <= ST_RUN;
					end else if (timer_q >= wait_ticks) begin
						o_result <= RES_NO_DIALTONE;
						o_result_valid <= 1'b1;
						o_off_hook <= 1'b0;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_PAUSE: begin
					if (timer_q >= pause_ticks)
						state_q <= ST_RUN;
				end
				ST_QUIET: begin
					// silence only counts after dial tone then a long signal
					if (line_q.dial_tone)
						saw_tone_q <= 1'b1;
					if (tick)
						// dial tone itself must not arm the silence timer
						sub_q <= line_q.other_signal && saw_tone_q
							? sub_q + 16'd1 : (armed_q ? sub_q + 16'd1 : 16'd0);
					if (!armed_q && 32'(sub_q) >= SIGNAL_TICKS && !line_q.other_signal) begin
						armed_q <= 1'b1;
						sub_q <= '0;
					end
					if (armed_q && (line_q.other_signal || line_q.dial_tone))
						sub_q <= '0;
					if (armed_q && 32'(sub_q) >= SILENCE_S * 100) begin
						state_q <= ST_RUN;
					end else if (timer_q >= wait_ticks) begin
						o_result <= RES_NO_ANSWER;
						o_result_valid <= 1'b1;
						o_off_hook <= 1'b0;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_FLASH: begin
					if (32'(timer_q) >= FLASH_TICKS) begin
						o_off_hook <= 1'b1;
						state_q <= ST_RUN;
					end
				end
				ST_DONE: begin
					o_result_valid <= 1'b1;
					o_busy <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
			// a terminal character during a timed wait aborts with ok
			if (i_char_valid && state_q inside {ST_INIT, ST_WAIT, ST_PAUSE, ST_QUIET, ST_FLASH}) begin
				o_result <= RES_OK;
				o_result_valid <= 1'b1;
				o_off_hook <= 1'b0;
				o_busy <= 1'b0;
				state_q <= ST_IDLE;
			end
		end
	end

	a_reject_online: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && i_dial_start && i_cfg.on_line |=> o_result_valid && o_result == RES_ERROR && !o_busy)
		else $error("dial accepted while on-line");
	a_pulse_drops: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_RUN && i_char_valid && !o_tone_mode && i_char == 8'h23 && !i_term_ready_abort
		&& 32'(count_q) < BUF_CHARS |=> !o_digit.valid)
		else $error("tone symbol dialed in pulse mode");
	a_digit_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_RUN && i_char_valid && is_digit(i_char) && !i_term_ready_abort && !line_q.busy_tone
		&& 32'(count_q) < BUF_CHARS |=> o_digit.valid && o_digit.symbol == $past(i_char))
		else $error("digit not dialed");
	a_offhook_skip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_IDLE && i_dial_start && o_off_hook && !i_cfg.on_line && !i_cfg.sync_mode_two
		&& !i_cfg.sync_mode_three && !i_stored_valid |=> state_q == ST_RUN)
		else $error("off-hook dial did not skip waits");
	a_flash_onhook: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_FLASH |-> !o_off_hook)
		else $error("hookflash left line connected");
	a_carrier_hs: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_carrier_valid && i_carrier_off_req && !i_low_speed |=> $stable(o_tx_carrier_forced_off))
		else $error("high-speed device took carrier off");
	a_pp_select: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_std_valid && i_std_code == STD_4800_PP |=> o_std_4800 == MOD_PINGPONG && $stable(o_std_9600))
		else $error("4800 ping-pong selection wrong");
	a_wait_timeout: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == ST_WAIT && !line_q.dial_tone && !i_char_valid && timer_q >= wait_ticks
		|=> o_result == RES_NO_DIALTONE && !o_off_hook)
		else $error("wait timeout not reported");
	a_tone_reset: assert property (@(posedge i_clk_sys)
		i_rst |=> !o_tone_mode)
		else $error("reset did not restore pulse");
endmodule // modem_dial_command_sequencer
`default_nettype wire

// *** test/term_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// terminal and line stand-in: dial-string characters plus line conditions
module term_model
	import dial_seq_pkg::*;
(
	input wire logic i_clk_sys,
	output logic o_char_valid,
	output logic [7:0] o_char,
	output line_s o_line
);
	initial begin
		o_char_valid = 1'b0;
		o_char = 8'h00;
		o_line = '0;
	end

	// one character per call, held across the taking edge
	task automatic send(input logic [7:0] c);
		@(negedge i_clk_sys);
		o_char_valid = 1'b1;
		o_char = c;
		@(negedge i_clk_sys);
		o_char_valid = 1'b0;
		o_char = ~c; // released data shows junk, not the last value
	endtask

	// line conditions are levels; the design syncs them itself
	task automatic set_line(input line_s l);
		@(negedge i_clk_sys);
		o_line = l;
	endtask
endmodule // term_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module tb;
	import dial_seq_pkg::*;
	localparam int TL = 10;
	localparam int SEC = (1000 / TICK_MS) * TL; // cycles per second at the short tick
	logic clk_sys = 1'b0, rst = 1'b1, char_valid, dial_start = 1'b0, std_valid = 1'b0;
	logic carrier_valid = 1'b0, carrier_off_req = 1'b0, low_speed = 1'b0;
	logic method_valid = 1'b0, method_tone = 1'b0, stored_valid = 1'b0, abort = 1'b0;
	logic [7:0] ch;
	logic [6:0] std_code = 7'h00;
	logic [2:0] stored_index = 3'h0;
	logic [8:0] stored_len = 9'h000;
	cfg_s cfg = '0;
	line_s line;
	logic cmd_reject, forced_off, tone_mode, off_hook, originate, busy, result_valid;
	mod_std_e std_4800, std_9600, std_2400;
	digit_s digit;
	result_e result;
	int err_count = 0;
	int comparisons = 0;

	always #25 clk_sys = ~clk_sys;

	term_model u_term_model (.i_clk_sys(clk_sys), .o_char_valid(char_valid), .o_char(ch),
		.o_line(line));
	modem_dial_command_sequencer #(.TICK_LEN(TL)) u_modem_dial_command_sequencer (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_char_valid(char_valid), .i_char(ch),
		.i_dial_start(dial_start), .i_std_valid(std_valid), .i_std_code(std_code),
		.i_carrier_valid(carrier_valid), .i_carrier_off_req(carrier_off_req),
		.i_low_speed(low_speed), .i_method_valid(method_valid), .i_method_tone(method_tone),
		.i_stored_valid(stored_valid), .i_stored_index(stored_index),
		.i_stored_len(stored_len), .i_cfg(cfg), .i_line_async(line),
		.i_term_ready_abort(abort), .o_cmd_reject(cmd_reject), .o_std_4800(std_4800),
		.o_std_9600(std_9600), .o_std_2400(std_2400), .o_tx_carrier_forced_off(forced_off),
		.o_tone_mode(tone_mode), .o_off_hook(off_hook), .o_originate(originate),
		.o_digit(digit), .o_busy(busy), .o_result_valid(result_valid), .o_result(result));

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// the result pulse may come late; poll it under a bound
	task automatic wait_res(input result_e e, input int n);
		int i;
		for (i = 0; i < n && result_valid !== 1'b1; i++) @(negedge clk_sys);
		`CHK(result_valid, 1'b1);
		`CHK(result, e);
	endtask

	task automatic wait_digit(input logic [7:0] s, input logic t);
		int i;
		for (i = 0; i < 8 && digit.valid !== 1'b1; i++) @(negedge clk_sys);
		`CHK({digit.valid, digit.tone, digit.symbol}, {1'b1, t, s});
	endtask

	task automatic pulse_dial();
		@(negedge clk_sys);
		dial_start = 1'b1;
		@(negedge clk_sys);
		dial_start = 1'b0;
	endtask

	task automatic set_method(input logic t);
		@(negedge clk_sys);
		method_valid = 1'b1;
		method_tone = t;
		@(negedge clk_sys);
		method_valid = 1'b0;
		`CHK(tone_mode, t);
	endtask

	task automatic t_reset();
		`CHK({std_2400, std_4800, std_9600}, {MOD_V22BIS, MOD_V32, MOD_V32});
		`CHK({tone_mode, off_hook, forced_off, busy}, 4'h0);
	endtask

	// every code of every group; later codes must not disturb other groups
	task automatic t_std();
		logic [6:0] codes [6] = '{STD_2400, STD_4800_FD, STD_4800_PP,
			STD_9600_FD, STD_9600_PP, STD_9600_HD};
		mod_std_e exp [6] = '{MOD_V22BIS, MOD_V32, MOD_PINGPONG,
			MOD_V32, MOD_PINGPONG, MOD_V29_HDX};
		int i;
		for (i = 0; i < 6; i++) begin
			@(negedge clk_sys);
			std_valid = 1'b1;
			std_code = codes[i];
			#1 `CHK(cmd_reject, 1'b0);
			@(negedge clk_sys);
			std_valid = 1'b0;
			`CHK(i < 3 ? (i == 0 ? std_2400 : std_4800) : std_9600, exp[i]);
		end
		`CHK({std_2400, std_4800, std_9600}, {MOD_V22BIS, MOD_PINGPONG, MOD_V29_HDX});
		@(negedge clk_sys);
		std_valid = 1'b1;
		std_code = 7'h1f; // code outside every group
		#1 `CHK(cmd_reject, 1'b1);
		@(negedge clk_sys);
		std_valid = 1'b0;
	endtask

	// forced-off only on a low-speed strap; normal always accepted
	task automatic t_carrier();
		logic [1:0] c [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
		int i;
		for (i = 0; i < 4; i++) begin
			@(negedge clk_sys);
			low_speed = c[i][1];
			carrier_valid = 1'b1;
			carrier_off_req = c[i][0];
			#1 `CHK(cmd_reject, c[i] == 2'b01);
			@(negedge clk_sys);
			carrier_valid = 1'b0;
			`CHK(forced_off, c[i] == 2'b11);
		end
	endtask

	// on-line and both restrictive sync settings refuse the dial
	task automatic t_refuse();
		int i;
		for (i = 0; i < 3; i++) begin
			cfg.on_line = (i == 0);
			cfg.sync_mode_two = (i == 1);
			cfg.sync_mode_three = (i == 2);
			pulse_dial();
			wait_res(RES_ERROR, 4);
			`CHK({off_hook, busy, originate}, 3'h0);
		end
		cfg = '0;
		cfg.pause_time = 8'h01;
		cfg.carrier_wait_time = 8'h01;
	endtask

	// bad stored slot and stored string overflowing the buffer
	task automatic t_store();
		@(negedge clk_sys);
		stored_valid = 1'b1;
		stored_index = 3'(STORED_SLOTS);
		pulse_dial();
		wait_res(RES_ERROR, 4);
		stored_index = 3'h0;
		stored_len = 9'(BUF_BASIC + 1);
		pulse_dial();
		wait_res(RES_ERROR, 4);
		stored_valid = 1'b0;
		`CHK(off_hook, 1'b0);
	endtask

	// pulse call: digit, ignored tone symbol, comma pause, semicolon
	task automatic t_dial_pulse();
		u_term_model.set_line('{dial_tone: 1'b1, busy_tone: 1'b0, other_signal: 1'b0});
		pulse_dial();
		`CHK({off_hook, busy, originate}, 3'h7);
		cycles((INIT_WAIT_S + DIALTONE_S + 1) * SEC);
		u_term_model.send("5");
		wait_digit("5", 1'b0);
		u_term_model.send("A");
		cycles(4);
		`CHK(digit.valid, 1'b0);
		u_term_model.send(CH_COMMA);
		cycles(SEC + 20);
		u_term_model.send("7");
		wait_digit("7", 1'b0);
		u_term_model.send(CH_SEMI);
		wait_res(RES_OK, 4);
		`CHK(off_hook, 1'b1);
	endtask

	// still off hook: no initial wait, tone symbol dials, flash breaks the loop
	task automatic t_dial_tone();
		int i;
		set_method(1'b1);
		pulse_dial();
		u_term_model.send("B");
		wait_digit("B", 1'b1);
		u_term_model.send(CH_FLASH);
		for (i = 0; i < FLASH_TICKS * TL + 20 && off_hook !== 1'b0; i++) @(negedge clk_sys);
		`CHK(off_hook, 1'b0);
		for (i = 0; i < FLASH_TICKS * TL + 20 && off_hook !== 1'b1; i++) @(negedge clk_sys);
		`CHK(off_hook, 1'b1);
		cycles(4);
		u_term_model.send("9");
		wait_digit("9", 1'b1);
		u_term_model.send(CH_CR);
		wait_res(RES_DIALED, 6);
	endtask

	// wait modifier without dial tone, then a character cutting a pause
	task automatic t_timeouts();
		@(negedge clk_sys);
		rst = 1'b1;
		cycles(2);
		rst = 1'b0;
		`CHK(tone_mode, 1'b0);
		pulse_dial();
		cycles((INIT_WAIT_S + DIALTONE_S + 1) * SEC);
		u_term_model.set_line('0);
		u_term_model.send(CH_WAIT);
		wait_res(RES_NO_DIALTONE, 3 * SEC);
		`CHK(off_hook, 1'b0);
		u_term_model.set_line('{dial_tone: 1'b1, busy_tone: 1'b0, other_signal: 1'b0});
		pulse_dial();
		cycles((INIT_WAIT_S + DIALTONE_S + 1) * SEC);
		u_term_model.send(CH_COMMA);
		u_term_model.send("3");
		wait_res(RES_OK, 6);
	endtask

	// quiet answer: tone, long ring, silence resumes; then no answer; busy; abort
	task automatic t_quiet();
		cfg.carrier_wait_time = 8'h08;
		pulse_dial();
		cycles(3 * SEC);
		u_term_model.send(CH_QUIET);
		cycles(SEC / 2);
		u_term_model.set_line('{dial_tone: 1'b0, busy_tone: 1'b0, other_signal: 1'b1});
		cycles(SEC / 2);
		u_term_model.set_line('0);
		cycles(6 * SEC);
		`CHK(busy, 1'b1);
		u_term_model.send("1");
		wait_digit("1", 1'b0);
		cfg.carrier_wait_time = 8'h02;
		u_term_model.send(CH_QUIET);
		wait_res(RES_NO_ANSWER, 3 * SEC);
		`CHK(off_hook, 1'b0);
		cfg.result_set_three = 1'b1;
		pulse_dial();
		cycles(3 * SEC);
		u_term_model.set_line('{dial_tone: 1'b0, busy_tone: 1'b1, other_signal: 1'b0});
		wait_res(RES_BUSY, 6);
		u_term_model.set_line('0);
		cfg.result_set_three = 1'b0;
		pulse_dial();
		cycles(3 * SEC);
		abort = 1'b1;
		wait_res(RES_OK, 4);
		abort = 1'b0;
		`CHK({off_hook, busy}, 2'h0);
	endtask

	initial begin
		cycles(10);
		rst = 1'b0;
		t_reset();
		t_std();
		t_carrier();
		set_method(1'b1);
		set_method(1'b0);
		t_refuse();
		t_store();
		t_dial_pulse();
		t_dial_tone();
		t_timeouts();
		t_quiet();
		close_out();
	end

	// the scenarios need roughly 33k cycles; cut off well beyond that
	initial begin
		cycles(60 * SEC);
		err_count++;
		close_out();
	end
endmodule // tb
`default_nettype wire
